/* verification/aotp_chk_sva.sv */
`timescale 1ns/1ps
module aotp_chk
  import aotp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [11:0] convCodeA,
  input wire logic [11:0] ditherA,
  input wire logic trigger_mark_input,
  input wire logic sysref,
  input wire logic [11:0] sampOutA,
  input wire logic [11:0] sampOutB,
  input wire logic frameStrobe,
  input wire logic chan_a_flag_hi,
  input wire logic chan_b_flag_lo
);
  logic [7:0] ctl_r, near_r, low_r;
  function automatic logic [7:0] m8(input logic [11:0] s);
    logic [11:0] m;
    m = s[11] ? ((s == 12'h800) ? 12'h7ff : 12'(-s)) : s;
    return m[10:3];
  endfunction : m8
  // Shadow of the settings, so relations hold across reprogramming
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_r <= 8'h10;
      near_r <= RST_NEAR_FULL;
      low_r <= RST_LOW_LEVEL;
    end else if (regWr && regAddr == OFS_CTRL) begin
      ctl_r <= regWdata[7:0];
    end else if (regWr && regAddr == OFS_THRESH) begin
      {low_r, near_r} <= regWdata[15:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_hold_a_hi: assert property ($rose(chan_a_flag_hi) |-> chan_a_flag_hi[*8])
    else $error("flag A hi dropped early");
  a_hold_b_lo: assert property ($rose(chan_b_flag_lo) |-> chan_b_flag_lo[*8])
    else $error("flag B lo dropped early");
  a_cause_a_hi: assert property ($rose(chan_a_flag_hi) && !ctl_r[1]
    && near_r == $past(near_r, 3) |-> m8(sampOutA) >= near_r)
    else $error("flag A hi without hit");
  a_cause_b_lo: assert property ($rose(chan_b_flag_lo) && !ctl_r[1]
    && low_r == $past(low_r, 3) |-> m8(sampOutB) >= low_r)
    else $error("flag B lo without hit");
  a_thr_read: assert property ($past(regRd) && $past(regAddr) == OFS_THRESH
    |-> regRdata == {16'h0, low_r, near_r})
    else $error("threshold readback wrong");
  a_mark_bit: assert property (ctl_r[1] && ctl_r == $past(ctl_r, 3) && !$past(srst, 2)
    |-> sampOutA[0] == (ctl_r[2] ? $past(sysref, 2) : $past(trigger_mark_input, 2)))
    else $error("mark bit wrong");
  a_plain_out: assert property (!ctl_r[1] && ctl_r == $past(ctl_r, 3) && !$past(srst, 2)
    |-> sampOutA == 12'($past(convCodeA, 2) - $past(ditherA, 2)))
    else $error("sample out wrong");
  a_ref_strobe: assert property ($rose(sysref) |=> frameStrobe)
    else $error("no strobe after ref pulse");
endmodule : aotp_chk
bind aotp_overrange_path aotp_chk u_chk (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .convCodeA(convCodeA), .ditherA(ditherA), .trigger_mark_input(trigger_mark_input),
  .sysref(sysref), .sampOutA(sampOutA), .sampOutB(sampOutB), .frameStrobe(frameStrobe),
  .chan_a_flag_hi(chan_a_flag_hi), .chan_b_flag_lo(chan_b_flag_lo));

/* verification/aotp_rx_model.sv */
`timescale 1ns/1ps
module aotp_rx_model #(
  parameter int QUIET = 64
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic singleMode,
  input wire logic aHi,
  input wire logic aLo,
  input wire logic bHi,
  input wire logic bLo,
  output logic overHi,
  output logic overLo,
  output logic gainUp
);
  logic [15:0] quiet_r;
  // Lanes split the stream in single mode, so either lane counts
  assign overHi = aHi | (singleMode & bHi);
  assign overLo = aLo | (singleMode & bLo);
  assign gainUp = quiet_r == 16'(QUIET);
  always_ff @(posedge clk_sys) begin
    if (srst || overLo || overHi) begin
      quiet_r <= 16'h0;
    end else if (!gainUp) begin
      quiet_r <= quiet_r + 16'h1;
    end
  end
endmodule : aotp_rx_model

/* verification/tb_aotp_overrange_path.sv */
`timescale 1ns/1ps
module tb_aotp_overrange_path;
  import aotp_pkg::*;
  logic clk_sys, srst, regWr, regRd, trig, sysref, strb, single;
  logic aHi, aLo, bHi, bLo, overHi, overLo, gainUp;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [11:0] codeA, codeB, ditA, ditB, outA, outB;
  int error_cnt, cmp_count;
  logic [11:0] cv [8] = '{12'h7ff, 12'h800, 12'h720, 12'h71f, 12'h8e0, 12'h200, 12'h1ff, 12'h8e1};
  logic [1:0] ev [8] = '{2'b11, 2'b11, 2'b11, 2'b01, 2'b11, 2'b01, 2'b00, 2'b01};
  aotp_overrange_path dut (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .convCodeA(codeA), .convCodeB(codeB), .ditherA(ditA), .ditherB(ditB),
    .trigger_mark_input(trig), .sysref(sysref), .sampOutA(outA), .sampOutB(outB),
    .frameStrobe(strb), .chan_a_flag_hi(aHi), .chan_a_flag_lo(aLo),
    .chan_b_flag_hi(bHi), .chan_b_flag_lo(bLo));
  aotp_rx_model rx (.clk_sys(clk_sys), .srst(srst), .singleMode(single), .aHi(aHi),
    .aLo(aLo), .bHi(bHi), .bLo(bLo), .overHi(overHi), .overLo(overLo), .gainUp(gainUp));
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {regWr, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    regWr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge clk_sys);
    regRd <= 0;
    #1 chk(regRdata, exp);
  endtask : rd
  task automatic t_regs;
    rd(OFS_THRESH, {16'h0, RST_LOW_LEVEL, RST_NEAR_FULL});
    rd(OFS_HOLD, 32'(RST_HOLD_SEL));
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    wr(OFS_THRESH, 32'hffff_4321);
    rd(OFS_THRESH, 32'h4321);
    wr(OFS_THRESH, {16'h0, RST_LOW_LEVEL, RST_NEAR_FULL});
  endtask : t_regs
  task automatic t_path;
    @(posedge clk_sys);
    {codeA, ditA, codeB, ditB} <= {12'h123, 12'h005, 12'h000, 12'h001};
    tick(3);
    chk(outA, 12'h11e);
    chk(outB, 12'hfff);
    {ditA, ditB} <= 24'h0;
  endtask : t_path
  task automatic t_flags;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      {codeA, codeB} <= {cv[i], 12'h000};
      @(posedge clk_sys);
      codeA <= 12'h000;
      tick(1);
      chk({aHi, aLo, bHi, bLo}, {ev[i], 2'b00});
      tick(12);
    end
    tick(64);
    chk(gainUp, 1'b1);
    single <= 1;
    wr(OFS_CTRL, 32'h11);
    codeB <= 12'h7ff;
    @(posedge clk_sys);
    codeB <= 12'h000;
    tick(1);
    chk({aHi, aLo, bHi, bLo, overHi, overLo}, 6'b001111);
    tick(1);
    chk(gainUp, 1'b0);
    rd(OFS_STATUS, (32'h1 << STAT_MODE_BIT) | (32'hc << STAT_FLAG_LSB));
    single <= 0;
    wr(OFS_CTRL, 32'h10);
    tick(12);
  endtask : t_flags
  task automatic t_hold;
    int n;
    for (int s = 0; s < 8; s++) begin
      wr(OFS_HOLD, 32'(s));
      codeA <= 12'h7ff;
      @(posedge clk_sys);
      codeA <= 12'h000;
      tick(1);
      n = 0;
      while (aHi === 1'b1 && n < 2000) begin
        n++;
        tick(1);
      end
      chk(32'(n), 32'(8 << s));
    end
    wr(OFS_HOLD, 32'h0);
  endtask : t_hold
  task automatic t_mark;
    wr(OFS_CTRL, 32'h12);
    @(posedge clk_sys);
    {codeA, trig} <= {12'h554, 1'b1};
    tick(2);
    chk(outA, 12'h555);
    chk(outB, 12'h001);
    {codeA, trig} <= {12'h555, 1'b0};
    tick(2);
    chk(outA, 12'h554);
    wr(OFS_CTRL, 32'h16);
    {codeA, sysref} <= {12'h554, 1'b1};
    tick(2);
    chk(outA, 12'h555);
    {codeA, sysref} <= 13'h0;
    wr(OFS_CTRL, 32'h10);
  endtask : t_mark
  task automatic t_strobe;
    for (int d = 0; d < 2; d++) begin
      wr(OFS_CTRL, 32'h40 | 32'(d << 3));
      sysref <= 1;
      @(posedge clk_sys);
      sysref <= 0;
      #1 chk(strb, 1'b1);
      tick((d + 1) * 4 - 1);
      chk(strb, 1'b0);
      tick(1);
      chk(strb, 1'b1);
    end
    rd(OFS_REFCNT, 32'h3);
  endtask : t_strobe
  task automatic wrap_up;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    {srst, regWr, regRd, trig, sysref, single} = 6'b100000;
    {regAddr, regWdata, codeA, codeB, ditA, ditB} = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk_sys);
    srst <= 0;
    t_regs();
    t_path();
    t_flags();
    t_hold();
    t_mark();
    t_strobe();
    wrap_up();
  end
endmodule : tb_aotp_overrange_path

/* verilog/aotp_flag_stretch.sv */
`timescale 1ns/1ps
module aotp_flag_stretch
  import aotp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [aotp_pkg::SAMP_W-1:0] sample,
  input wire logic [aotp_pkg::CMP_W-1:0] nearFullThreshold,
  input wire logic [aotp_pkg::CMP_W-1:0] lowLevelThreshold,
  input wire logic [2:0] flagHoldLengthSelect,
  output logic flagHi,
  output logic flagLo
);
  import aotp_pkg::*;

  typedef struct packed {
    logic [1:0][HOLD_W-1:0] cnt;
    logic [1:0] flag;
  } aotp_fs_state_t;

  aotp_fs_state_t st_r;
  aotp_fs_state_t st_nxt;
  logic [CMP_W-1:0] mag;
  logic [1:0] hit;

  always_comb begin
    st_nxt = st_r;
    mag = aotp_mag8(sample);
    hit[0] = (mag >= nearFullThreshold);
    hit[1] = (mag >= lowLevelThreshold);
    for (int i = 0; i < 2; i++) begin
      if (hit[i]) begin
        // Each new event restarts the hold
        st_nxt.flag[i] = 1'b1;
        st_nxt.cnt[i] = aotp_hold_len(flagHoldLengthSelect);
      end else if (st_r.cnt[i] != '0) begin
        st_nxt.cnt[i] = st_r.cnt[i] - HOLD_W'(1);
      end else begin
        st_nxt.flag[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flagHi = st_r.flag[0];
  assign flagLo = st_r.flag[1];

endmodule : aotp_flag_stretch

/* verilog/aotp_overrange_path.sv */
`timescale 1ns/1ps
module aotp_overrange_path
  import aotp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [aotp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [aotp_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [aotp_pkg::DATA_W-1:0] regRdata,
  input wire logic [aotp_pkg::SAMP_W-1:0] convCodeA,
  input wire logic [aotp_pkg::SAMP_W-1:0] convCodeB,
  input wire logic [aotp_pkg::SAMP_W-1:0] ditherA,
  input wire logic [aotp_pkg::SAMP_W-1:0] ditherB,
  input wire logic trigger_mark_input,
  input wire logic sysref,
  output logic [aotp_pkg::SAMP_W-1:0] sampOutA,
  output logic [aotp_pkg::SAMP_W-1:0] sampOutB,
  output logic frameStrobe,
  output logic chan_a_flag_hi,
  output logic chan_a_flag_lo,
  output logic chan_b_flag_hi,
  output logic chan_b_flag_lo
);
  import aotp_pkg::*;

  typedef struct packed {
    aotp_mode_t mode;
    logic markInsertEnable;
    logic refpulseMarkSelect;
    logic laneDemuxSetting;
    logic [FRAME_W-1:0] frameLengthSetting;
    logic [CMP_W-1:0] nearFullThreshold;
    logic [CMP_W-1:0] lowLevelThreshold;
    logic [2:0] flagHoldLengthSelect;
    logic [DATA_W-1:0] rdata;
    logic [SAMP_W-1:0] stgA;
    logic [SAMP_W-1:0] stgB;
    logic markStgA;
    logic markStgB;
    logic [SAMP_W-1:0] outA;
    logic [SAMP_W-1:0] outB;
    logic refPrev;
    logic [DIV_W-1:0] divCnt;
    logic strobe;
    logic [CNT_W-1:0] refCount;
  } aotp_top_state_t;

  aotp_top_state_t st_r;
  aotp_top_state_t st_nxt;

  logic markSrc;
  logic refEvent;
  logic [DIV_W-1:0] divLast;
  logic [3:0] flagVec;

  // Both lanes go through the same threshold pair
  aotp_flag_stretch u_flag_a (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample(st_r.stgA),
    .nearFullThreshold(st_r.nearFullThreshold),
    .lowLevelThreshold(st_r.lowLevelThreshold),
    .flagHoldLengthSelect(st_r.flagHoldLengthSelect),
    .flagHi(chan_a_flag_hi),
    .flagLo(chan_a_flag_lo)
  );

  aotp_flag_stretch u_flag_b (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample(st_r.stgB),
    .nearFullThreshold(st_r.nearFullThreshold),
    .lowLevelThreshold(st_r.lowLevelThreshold),
    .flagHoldLengthSelect(st_r.flagHoldLengthSelect),
    .flagHi(chan_b_flag_hi),
    .flagLo(chan_b_flag_lo)
  );

  assign flagVec = {chan_b_flag_lo, chan_b_flag_hi, chan_a_flag_lo, chan_a_flag_hi};

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;

    // Mark source choice; trigger arrives already aligned to clk_sys
    markSrc = st_r.refpulseMarkSelect ? sysref : trigger_mark_input;

    // Reference pulse is taken on its rising edge only
    refEvent = sysref && !st_r.refPrev;
    st_nxt.refPrev = sysref;

    // Divider wraps after (demux+1) * frame cycles
    divLast = DIV_W'((32'(st_r.laneDemuxSetting) + 32'h1)
      * 32'(st_r.frameLengthSetting) - 32'h1);

    // Register writes
    if (regWr) begin
      if (regAddr == OFS_CTRL) begin
        st_nxt.mode = aotp_mode_t'(regWdata[CTRL_SINGLE_BIT]);
        st_nxt.markInsertEnable = regWdata[CTRL_MARK_EN_BIT];
        st_nxt.refpulseMarkSelect = regWdata[CTRL_REF_SEL_BIT];
        st_nxt.laneDemuxSetting = regWdata[CTRL_DEMUX_BIT];
        st_nxt.frameLengthSetting = regWdata[CTRL_FRAME_LSB +: FRAME_W];
      end else if (regAddr == OFS_THRESH) begin
        st_nxt.nearFullThreshold = regWdata[THR_NEAR_LSB +: CMP_W];
        st_nxt.lowLevelThreshold = regWdata[THR_LOW_LSB +: CMP_W];
      end else if (regAddr == OFS_HOLD) begin
        st_nxt.flagHoldLengthSelect = regWdata[2:0];
      end
    end

    // Register reads; unmapped offsets answer zero
    if (regRd) begin
      if (regAddr == OFS_CTRL) begin
        st_nxt.rdata[CTRL_SINGLE_BIT] = st_r.mode;
        st_nxt.rdata[CTRL_MARK_EN_BIT] = st_r.markInsertEnable;
        st_nxt.rdata[CTRL_REF_SEL_BIT] = st_r.refpulseMarkSelect;
        st_nxt.rdata[CTRL_DEMUX_BIT] = st_r.laneDemuxSetting;
        st_nxt.rdata[CTRL_FRAME_LSB +: FRAME_W] = st_r.frameLengthSetting;
      end else if (regAddr == OFS_THRESH) begin
        st_nxt.rdata[THR_NEAR_LSB +: CMP_W] = st_r.nearFullThreshold;
        st_nxt.rdata[THR_LOW_LSB +: CMP_W] = st_r.lowLevelThreshold;
      end else if (regAddr == OFS_HOLD) begin
        st_nxt.rdata[2:0] = st_r.flagHoldLengthSelect;
      end else if (regAddr == OFS_STATUS) begin
        st_nxt.rdata[STAT_FLAG_LSB +: 4] = flagVec;
        st_nxt.rdata[STAT_DIV_LSB +: DIV_W] = st_r.divCnt;
        st_nxt.rdata[STAT_MODE_BIT] = st_r.mode;
      end else if (regAddr == OFS_REFCNT) begin
        st_nxt.rdata[CNT_W-1:0] = st_r.refCount;
      end
    end

    // Lane A holds the rising-edge sample; lane B the falling-edge one in
    // single mode, or channel B in dual mode. Same path either way.
    st_nxt.stgA = convCodeA - ditherA;
    st_nxt.stgB = convCodeB - ditherB;

    // Mark captured with the analog sample, one stage like the data
    st_nxt.markStgA = markSrc;
    st_nxt.markStgB = markSrc;

    // Output stage, same latency for data, mark and flags
    if (st_r.markInsertEnable) begin
      st_nxt.outA = {st_r.stgA[SAMP_W-1:1], st_r.markStgA};
      st_nxt.outB = {st_r.stgB[SAMP_W-1:1], st_r.markStgB};
    end else begin
      st_nxt.outA = st_r.stgA;
      st_nxt.outB = st_r.stgB;
    end

    // Divider and strobe; a reference edge restarts both
    if (refEvent) begin
      st_nxt.divCnt = '0;
      st_nxt.strobe = 1'b1;
      st_nxt.refCount = st_r.refCount + CNT_W'(1);
    end else if (st_r.divCnt >= divLast) begin
      // Also catches a frame shortened under a running count
      st_nxt.divCnt = '0;
      st_nxt.strobe = 1'b1;
    end else begin
      st_nxt.divCnt = st_r.divCnt + DIV_W'(1);
      st_nxt.strobe = 1'b0;
    end
  end

  // All logic on the single device clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.mode <= AOTP_DUAL;
      st_r.nearFullThreshold <= RST_NEAR_FULL;
      st_r.lowLevelThreshold <= RST_LOW_LEVEL;
      st_r.flagHoldLengthSelect <= RST_HOLD_SEL;
      st_r.frameLengthSetting <= RST_FRAME;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign sampOutA = st_r.outA;
  assign sampOutB = st_r.outB;
  assign frameStrobe = st_r.strobe;

endmodule : aotp_overrange_path

/* verilog/aotp_pkg.sv */
package aotp_pkg;

  localparam int SAMP_W = 12;
  localparam int CMP_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HOLD_W = 11;
  localparam int DIV_W = 6;
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_REFCNT = 8'h10;

  // Control register fields
  localparam int CTRL_SINGLE_BIT = 0;
  localparam int CTRL_MARK_EN_BIT = 1;
  localparam int CTRL_REF_SEL_BIT = 2;
  localparam int CTRL_DEMUX_BIT = 3;
  localparam int CTRL_FRAME_LSB = 4;
  localparam int FRAME_W = 4;

  // Threshold register fields
  localparam int THR_NEAR_LSB = 0;
  localparam int THR_LOW_LSB = 8;

  // Status register fields
  localparam int STAT_FLAG_LSB = 0;
  localparam int STAT_DIV_LSB = 8;
  localparam int STAT_MODE_BIT = 16;

  // Reset values
  localparam logic [7:0] RST_NEAR_FULL = 8'he4;
  localparam logic [7:0] RST_LOW_LEVEL = 8'h40;
  localparam logic [2:0] RST_HOLD_SEL = 3'h0;
  localparam logic [3:0] RST_FRAME = 4'h1;

  // Shortest flag hold is 8 cycles, i.e. two to the third
  localparam int HOLD_BASE_LOG2 = 3;

  typedef enum logic {AOTP_DUAL, AOTP_SINGLE} aotp_mode_t;

  // Saturated absolute value, bits ten down to three
  function automatic logic [CMP_W-1:0] aotp_mag8(input logic [SAMP_W-1:0] s);
    logic [SAMP_W-1:0] m;
    m = s;
    if (s[SAMP_W-1]) begin
      m = (s == 12'h800) ? 12'h7ff : 12'(-s);
    end
    return m[10:3];
  endfunction : aotp_mag8

  // Hold length minus one, for select 0..7 gives 7..1023
  function automatic logic [HOLD_W-1:0] aotp_hold_len(input logic [2:0] sel);
    return HOLD_W'((32'h1 << (32'(sel) + HOLD_BASE_LOG2)) - 32'h1);
  endfunction : aotp_hold_len

endpackage : aotp_pkg
